// >>> sag_pkg.sv
// package: constants for the sfr access and write guard block
package sag_pkg;
    // wishbone byte addresses of the block's registers
    localparam logic [7:0] SYSCON_ADDR = 8'h00;
    localparam logic [7:0] GUARD_ADDR = 8'h04;
    localparam logic [7:0] PORT_PAGE_ADDR = 8'h08;
    localparam logic [7:0] MODULE_PAGE_REGISTER_ADDR = 8'h0C;
    localparam logic [7:0] PROT_ADDR = 8'h10;
    // system control register fields
    localparam int AREA_SEL_BIT = 0;
    localparam logic [7:0] SYSCON_RESET = 8'h04;
    localparam logic [7:0] SYSCON_ONES = 8'h04;
    // guard register fields
    localparam int MODE_LSB = 0;
    localparam int LOCKED_BIT = 2;
    localparam int KEY_LSB = 3;
    localparam logic [1:0] MODE_RESET = 2'h3;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [4:0] KEY_MODE = 5'h18;
    localparam logic [4:0] KEY_OPEN = 5'h13;
    localparam logic [4:0] KEY_CLOSE = 5'h15;
    // port page, module page and protected control registers
    localparam logic [7:0] PORT_PAGE_ADDR_SFR = 8'hB2;
    localparam logic [7:0] PORT_PAGE_RESET = 8'h00;
    localparam logic [7:0] MODULE_PAGE_REGISTER_RESET = 8'h00;
    localparam logic [7:0] PROT_RESET = 8'h00;
    localparam logic [2:0] PAGE_MASK = 3'h7;
endpackage

// >>> sag_sfr_if.sv
// interface: decoded cpu sfr access between guard core and decoder
`timescale 1ns/1ns
interface sag_sfr_if;
    logic [7:0] sfr_addr;
    logic area_sel;
    logic [2:0] page;
    logic std_hit;
    logic map_hit;
    logic [10:0] ext_addr;
    logic port_page_hit;
    modport core (output sfr_addr, area_sel, page, input std_hit, map_hit, ext_addr,
        port_page_hit);
    modport dec (input sfr_addr, area_sel, page, output std_hit, map_hit, ext_addr,
        port_page_hit);
endinterface

// >>> sag_decode.sv
// module: sfr area and page address decoder
`timescale 1ns/1ns
module sag_decode (
    // decoded access
    sag_sfr_if.dec sfr
);
    import sag_pkg::*;

    // area select steers every access into one of two areas
    assign sfr.std_hit = !sfr.area_sel;
    assign sfr.map_hit = sfr.area_sel;
    // extended address comes from the page field, never the instruction
    assign sfr.ext_addr = {sfr.page, sfr.sfr_addr};
    assign sfr.port_page_hit = !sfr.area_sel && (sfr.sfr_addr == PORT_PAGE_ADDR_SFR);
endmodule // sag_decode

// >>> sag_guard.sv
// module: sfr access control with password write guard, wishbone slave
`timescale 1ns/1ns
module sag_guard (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // cpu sfr address probe
    input wire logic [7:0] sfr_addr_i,
    // status and control to the rest of the chip
    output logic sfr_area_select_o,
    output logic std_hit_o,
    output logic map_hit_o,
    output logic [10:0] ext_addr_o,
    output logic port_page_hit_o,
    output logic [2:0] port_page_o,
    output logic [7:0] protected_ctrl_o,
    output logic locked_o
);
    import sag_pkg::*;

    sag_sfr_if sfr ();

    logic area_sel;
    logic [1:0] mode;
    logic mode_armed;
    logic locked;
    logic [7:0] port_page;
    logic [7:0] module_page_register;
    logic [7:0] prot;
    logic req;
    logic wr;
    logic mapped;
    logic [7:0] wbyte;
    logic [4:0] key;
    logic guard_on;
    logic [31:0] next_dat;

    assign req = cyc_i && stb_i && !ack_o && !err_o;
    assign mapped = (adr_i == SYSCON_ADDR) || (adr_i == GUARD_ADDR) ||
        (adr_i == PORT_PAGE_ADDR) || (adr_i == MODULE_PAGE_REGISTER_ADDR) || (adr_i == PROT_ADDR);
    assign wr = req && we_i && mapped && sel_i[0];
    assign wbyte = dat_i[7:0];
    assign key = wbyte[7:KEY_LSB];
    // every nonzero mode keeps the scheme on
    assign guard_on = (mode != MODE_OFF);

    // single-cycle answer; unmapped addresses get err
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            ack_o <= req && mapped;
            err_o <= req && !mapped;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            area_sel <= SYSCON_RESET[AREA_SEL_BIT];
        end else if (wr && adr_i == SYSCON_ADDR) begin
            // only the area bit is stored; reserved bits are constant
            area_sel <= wbyte[AREA_SEL_BIT];
        end
    end

    // guard key handling: three patterns, and the write after the arming key loads the mode; everything else ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= MODE_RESET;
            mode_armed <= 1'b0;
            locked <= 1'b1;
        end else if (wr && adr_i == GUARD_ADDR) begin
            // mode bits only land on the write after the arming key
            if (mode_armed) begin
                mode <= wbyte[MODE_LSB +: 2];
                mode_armed <= 1'b0;
            end else if (key == KEY_MODE) begin
                mode_armed <= 1'b1;
            end else if (key == KEY_OPEN && guard_on) begin
                locked <= 1'b0;
            end else if (key == KEY_CLOSE) begin
                locked <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_page <= PORT_PAGE_RESET;
        end else if (wr && adr_i == PORT_PAGE_ADDR) begin
            port_page <= {5'h00, wbyte[2:0] & PAGE_MASK};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            module_page_register <= MODULE_PAGE_REGISTER_RESET;
        end else if (wr && adr_i == MODULE_PAGE_REGISTER_ADDR) begin
            module_page_register <= {5'h00, wbyte[2:0] & PAGE_MASK};
        end
    end

    // protected control bits: writable only while the guard is open or off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prot <= PROT_RESET;
        end else if (wr && adr_i == PROT_ADDR && (!guard_on || !locked)) begin
            prot <= wbyte;
        end
    end

    // read mux; key field is write-only and reads zero
    always_comb begin
        next_dat = 32'h0000_0000;
        unique case (adr_i)
            SYSCON_ADDR: next_dat[7:0] = SYSCON_ONES | {7'h00, area_sel};
            // with the scheme off software may write everything, so the flag reads zero
            GUARD_ADDR: next_dat[7:0] = {5'h00, locked && guard_on, mode};
            PORT_PAGE_ADDR: next_dat[7:0] = port_page;
            MODULE_PAGE_REGISTER_ADDR: next_dat[7:0] = module_page_register;
            PROT_ADDR: next_dat[7:0] = prot;
            default: next_dat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && !we_i) begin
            dat_o <= next_dat;
        end
    end

    // port page register hits in the standard area use page 0; every other access pages from the module page register
    assign sfr.sfr_addr = sfr_addr_i;
    assign sfr.area_sel = area_sel;
    assign sfr.page = sfr.port_page_hit ? 3'h0 : module_page_register[2:0];

    sag_decode u_dec (
        .sfr(sfr)
    );

    assign sfr_area_select_o = area_sel;
    assign std_hit_o = sfr.std_hit;
    assign map_hit_o = sfr.map_hit;
    assign ext_addr_o = sfr.ext_addr;
    assign port_page_hit_o = sfr.port_page_hit;
    assign port_page_o = port_page[2:0];
    assign protected_ctrl_o = prot;
    // with the scheme off nothing is blocked
    assign locked_o = locked && guard_on;
endmodule // sag_guard

// >>> sag_guard_monitor.sv
// checker: port-level checks of the guard block
`timescale 1ns/1ns
module sag_guard_monitor import sag_pkg::*; (
    // bus side
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // decode and guard side
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_area_select_o,
    input wire logic std_hit_o,
    input wire logic map_hit_o,
    input wire logic [10:0] ext_addr_o,
    input wire logic port_page_hit_o,
    input wire logic [7:0] protected_ctrl_o,
    input wire logic locked_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rq, wq;
    // taken requests only: ack low at the taking edge
    assign rq = cyc_i && stb_i && !we_i && !ack_o;
    assign wq = cyc_i && stb_i && we_i && !ack_o;
    area_route_a: assert property (map_hit_o == sfr_area_select_o && std_hit_o != map_hit_o)
        else $error("area hit wrong");
    port_hit_a: assert property (port_page_hit_o == (!sfr_area_select_o && sfr_addr_i == PORT_PAGE_ADDR_SFR))
        else $error("port page hit wrong");
    ext_low_a: assert property (ext_addr_o[7:0] == sfr_addr_i)
        else $error("ext addr low wrong");
    area_write_a: assert property (wq && adr_i == SYSCON_ADDR |=> sfr_area_select_o == $past(dat_i[0]))
        else $error("area bit not stored");
    sys_read_a: assert property (rq && adr_i == SYSCON_ADDR |=> ack_o && dat_o[7:1] == 7'h02)
        else $error("control read wrong");
    key_read_a: assert property (rq && adr_i == GUARD_ADDR |=> dat_o[7:3] == 5'h00)
        else $error("key field not zero");
    prot_hold_a: assert property ($changed(protected_ctrl_o) |-> $past(wq && adr_i == PROT_ADDR && !locked_o))
        else $error("protected byte moved");
    lock_cause_a: assert property ($changed(locked_o) |-> $past(wq && adr_i == GUARD_ADDR))
        else $error("locked flag moved");
endmodule // sag_guard_monitor

// >>> test_sag_guard.sv
// testbench: self-checking run of the guard block
`timescale 1ns/1ns
module test_sag_guard;
    import sag_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [7:0] adr_i = 8'h00, sfr_addr_i = 8'h00, r;
    logic [3:0] sel_i = 4'h1;
    logic [31:0] dat_i = 32'h0000_0000, dat_o;
    logic ack_o, err_o, sfr_area_select_o, std_hit_o, map_hit_o, port_page_hit_o, locked_o;
    logic [10:0] ext_addr_o;
    logic [2:0] port_page_o;
    logic [7:0] protected_ctrl_o;
    logic [8:0] expq[$];
    int err_count = 0, n_tests = 0, cyc_cnt = 0, seed = 92152;
    always #20 clk_i = ~clk_i;
    sag_guard u_sag_guard (.*);
    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        n_tests++;
        if (e !== g) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one classic cycle; request held until ack or err is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h00_0000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [8:0] e);
        expq.push_back(e);
        wb(1'b0, a, 8'h00);
    endtask
    // result watcher, probe stimulus and hang guard
    always @(posedge clk_i) begin
        sfr_addr_i <= cyc_cnt[0] ? 8'hB2 : 8'($random(seed));
        if ((ack_o === 1'b1 || err_o === 1'b1) && !we_i && expq.size() > 0)
            chk("read", expq.pop_front(), (err_o === 1'b1) ? 9'h100 : {1'b0, dat_o[7:0]});
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(SYSCON_ADDR, 9'h004);
        rd(GUARD_ADDR, 9'h007);
        rd(PORT_PAGE_ADDR, 9'h000);
        rd(8'h20, 9'h100);
        repeat (4) begin
            r = 8'($random(seed));
            // reserved bits written back as they read
            wb(1'b1, SYSCON_ADDR, SYSCON_ONES | {7'h00, r[0]});
            chk("area", {8'h00, r[0]}, {8'h00, sfr_area_select_o});
            rd(SYSCON_ADDR, {8'h02, r[0]});
        end
        wb(1'b1, MODULE_PAGE_REGISTER_ADDR, 8'h05);
        rd(MODULE_PAGE_REGISTER_ADDR, 9'h005);
        chk("page", {6'h00, port_page_hit_o ? 3'h0 : 3'h5}, {6'h00, ext_addr_o[10:8]});
        wb(1'b1, PORT_PAGE_ADDR, 8'h03);
        rd(PORT_PAGE_ADDR, 9'h003);
        chk("port page", 9'h003, {6'h00, port_page_o});
        wb(1'b1, PROT_ADDR, 8'hA5);
        rd(PROT_ADDR, 9'h000);
        wb(1'b1, GUARD_ADDR, 8'h08);
        rd(GUARD_ADDR, 9'h007);
        wb(1'b1, GUARD_ADDR, {KEY_OPEN, 3'h0});
        rd(GUARD_ADDR, 9'h003);
        wb(1'b1, PROT_ADDR, r);
        rd(PROT_ADDR, {1'b0, r});
        wb(1'b1, GUARD_ADDR, {KEY_CLOSE, 3'h0});
        rd(GUARD_ADDR, 9'h007);
        wb(1'b1, PROT_ADDR, ~r);
        rd(PROT_ADDR, {1'b0, r});
        wb(1'b1, GUARD_ADDR, 8'h00);
        rd(GUARD_ADDR, 9'h007);
        wb(1'b1, GUARD_ADDR, {KEY_MODE, 3'h0});
        wb(1'b1, GUARD_ADDR, 8'h00);
        chk("locked", 9'h000, {8'h00, locked_o});
        rd(GUARD_ADDR, 9'h000);
        wb(1'b1, PROT_ADDR, ~r);
        rd(PROT_ADDR, {1'b0, ~r});
        wb(1'b1, GUARD_ADDR, {KEY_MODE, 3'h0});
        wb(1'b1, GUARD_ADDR, 8'h01);
        chk("locked", 9'h001, {8'h00, locked_o});
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(SYSCON_ADDR, 9'h004);
        rd(PROT_ADDR, 9'h000);
        repeat (2) @(posedge clk_i);
        print_verdict();
    end
endmodule // test_sag_guard
bind sag_guard sag_guard_monitor u_sag_guard_monitor (.*);
